/* design/ddr2_rap_consts.svh */
// Timing, width and burst constants for the DDR2 read auto-precharge pair
`ifndef DDR2_RAP_CONSTS_SVH
`define DDR2_RAP_CONSTS_SVH

// Command clock period and core times, in picoseconds
`define CK_PS        40000
`define T_RAS_PS     40000
`define T_RTP_PS     7500
`define T_RP_PS      15000
`define T_RCD_PS     15000

// Least time to whole cycles, rounded up, never below one
`define CEIL_CK(ps)  ((((ps) + `CK_PS - 1) / `CK_PS) < 1 ? 1 : (((ps) + `CK_PS - 1) / `CK_PS))

// Burst lengths and the prefetch spacing floor
`define BL_SHORT     4
`define BL_LONG      8
`define MIN_PF_GAP   2
`define WR_EXTRA     2

// Geometry
`define BANKS        4
`define BANK_W       2
`define COL_W        8
`define LANES        2
`define LANE_W       8
`define CNT_W        6
`define RL_MAX       15

`endif

/* design/ddr2_rap_pkg.sv */
// Types and small helpers shared by both ends of the DDR2 link
`include "ddr2_rap_consts.svh"

package ddr2_rap_pkg;

  typedef enum logic [2:0] {
    cmd_nop   = 3'h0,
    cmd_act   = 3'h1,
    cmd_read  = 3'h2,
    cmd_write = 3'h3,
    cmd_pre   = 3'h4
  } cmd_t;

  typedef enum logic [1:0] {
    op_read  = 2'h0,
    op_write = 2'h1,
    op_pre   = 2'h2
  } op_t;

  // Gray codes along idle, open, access
  typedef enum logic [1:0] {
    st_idle   = 2'h0,
    st_open   = 2'h1,
    st_access = 2'h3,
    st_close  = 2'h2
  } state_t;

  typedef logic [`CNT_W-1:0] cnt_t;

  // Spacing counter has run out at this edge
  function automatic logic elapsed(input cnt_t c);
    return c <= cnt_t'(1);
  endfunction

  // Counts down to zero and holds
  function automatic cnt_t tick(input cnt_t c);
    return (c == cnt_t'(0)) ? c : c - cnt_t'(1);
  endfunction

  function automatic cnt_t cmax(input cnt_t a, input cnt_t b);
    return (a > b) ? a : b;
  endfunction

endpackage

/* design/ddr2_link.sv */
// Command and read-data link between controller and DDR2 device
`timescale 1ns/1ns
`default_nettype none
`include "ddr2_rap_consts.svh"

interface ddr2_link;
  import ddr2_rap_pkg::*;

  cmd_t                     cmd;
  logic [`BANK_W-1:0]       bank;
  logic [`COL_W-1:0]        col;
  logic                     a10;
  logic [`LANES*`LANE_W-1:0] dq;
  logic [`LANES-1:0]        dq_oe;
  logic [`LANES-1:0]        dqs;
  logic [`LANES-1:0]        dqs_oe;

  modport dev (input cmd, input bank, input col, input a10,
               output dq, output dq_oe, output dqs, output dqs_oe);
  modport host (output cmd, output bank, output col, output a10,
                input dq, input dq_oe, input dqs, input dqs_oe);
endinterface

`default_nettype wire

/* design/ddr2_rap_device.sv */
// DDR2 device end: per-bank read auto-precharge timing and read data path
//
// What this block and the controller end do together
// R1 - A10 high on READ means auto precharge
// R2 - Precharge starts AL plus BL/2 edges later
// R3 - Postpone precharge until row-active and read-to-precharge elapse
// R4 - Row precharge count starts when precharge begins
// R5 - BL4: activate after AL plus rounded RTP+RP
// R6 - BL8: activate after AL+2 plus rounded RTP+RP
// R7 - Round summed RTP+RP over period upward
// R8 - Precharge never before last prefetch plus two
// R9 - Auto precharge runs while other banks work
// R10 - Other bank: read BL/2, precharge/activate 1 later
// R11 - Other bank write waits BL/2 plus two
// R12 - Explicit precharge spacing after plain READ
// R13 - Explicit precharge waits minimum row-active time
// R14 - Lower strobe bits 0-7, upper 8-15
// R15 - First data at AL plus CL
// R16 - RTP measured from last prefetch edge
// R17 - Separate timing counters for every bank
`include "ddr2_rap_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module ddr2_rap_device
  import ddr2_rap_pkg::*;
#(
  parameter int AL = 0,
  parameter int CL = 3,
  parameter int BL = `BL_SHORT
) (
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  ddr2_link.dev                   link,
  output logic [`BANKS-1:0]       bank_open_o,
  output logic [`BANKS-1:0]       ap_pending_o,
  output logic [`BANKS-1:0]       ap_start_o,
  output logic [`BANKS-1:0]       precharging_o
);

  localparam int   RL       = AL + CL;
  localparam int   HALF     = BL / 2;
  localparam int   LPF      = HALF - `MIN_PF_GAP;
  localparam cnt_t RAS_CK   = cnt_t'(`CEIL_CK(`T_RAS_PS));
  localparam cnt_t RTP_CK   = cnt_t'(`CEIL_CK(`T_RTP_PS));
  localparam cnt_t RP_CK    = cnt_t'(`CEIL_CK(`T_RP_PS));
  localparam cnt_t AP_BASE  = cnt_t'(AL + HALF);
  localparam cnt_t PF_FLOOR = cnt_t'(AL + LPF + `MIN_PF_GAP);
  localparam cnt_t RTP_LOAD = cnt_t'(AL + LPF) + RTP_CK;
  localparam cnt_t BEATS    = cnt_t'(HALF - 1);

  // Refuse settings the pipeline cannot serve
  generate
    if ((BL != `BL_SHORT && BL != `BL_LONG) || CL < 2 || AL < 0
        || RL > `RL_MAX) begin : g_bad_cfg
      $error("ddr2_rap_device: unsupported AL, CL or BL");
    end
  endgenerate

  // Per-bank timing state
  cnt_t ras_cnt [`BANKS];
  cnt_t rtp_cnt [`BANKS];
  cnt_t ap_cnt  [`BANKS];
  cnt_t rp_cnt  [`BANKS];
  cnt_t next_ras [`BANKS];
  cnt_t next_rtp [`BANKS];
  cnt_t next_ap  [`BANKS];
  cnt_t next_rp  [`BANKS];
  logic [`BANKS-1:0] next_open;
  logic [`BANKS-1:0] next_pend;
  logic [`BANKS-1:0] next_start;
  logic [`BANKS-1:0] next_prech;

  // Read latency pipeline and burst state
  logic [RL-1:0]      pipe_v;
  logic [`COL_W-1:0]  pipe_col [RL];
  logic [RL-1:0]      next_pipe_v;
  logic [`COL_W-1:0]  next_pipe_col [RL];
  cnt_t               beat_left;
  cnt_t               next_beat_left;
  logic [`COL_W-1:0]  beat_col;
  logic [`COL_W-1:0]  next_beat_col;
  logic               drive;
  logic               next_drive;
  logic               dqs_phase;
  logic               next_dqs_phase;

  // Bank timing: countdown, auto-precharge launch, command decode
  always_comb begin
    next_open  = bank_open_o;
    next_pend  = ap_pending_o;
    next_start = '0;
    for (int b = 0; b < `BANKS; b++) begin // R17
      next_ras[b] = tick(ras_cnt[b]);
      next_rtp[b] = tick(rtp_cnt[b]);
      next_ap[b]  = tick(ap_cnt[b]);
      next_rp[b]  = tick(rp_cnt[b]);
      // Launch once every minimum has run out
      if (ap_pending_o[b] && elapsed(ap_cnt[b]) && elapsed(ras_cnt[b])
          && elapsed(rtp_cnt[b])) begin // R2 R3 R8
        next_open[b]  = 1'b0;
        next_pend[b]  = 1'b0;
        next_start[b] = 1'b1;
        next_rp[b]    = RP_CK; // R4
      end
    end
    case (link.cmd)
      cmd_act: begin
        next_open[link.bank] = 1'b1;
        next_ras[link.bank]  = RAS_CK;
      end
      cmd_read: begin
        if (link.a10) begin // R1 R9
          next_pend[link.bank] = 1'b1;
          next_ap[link.bank]   = cmax(AP_BASE, PF_FLOOR); // R2 R8
          next_rtp[link.bank]  = RTP_LOAD; // R16
        end
      end
      cmd_pre: begin
        // A bank already closing on its own ignores it
        if (!ap_pending_o[link.bank]) begin
          next_open[link.bank] = 1'b0;
          next_rp[link.bank]   = RP_CK;
        end
      end
      default: begin
      end
    endcase
    // Precharging while the row precharge count has not reached zero
    for (int b = 0; b < `BANKS; b++) begin
      next_prech[b] = (next_rp[b] != cnt_t'(0)); // R4
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      bank_open_o   <= '0;
      ap_pending_o  <= '0;
      ap_start_o    <= '0;
      precharging_o <= '0;
      for (int b = 0; b < `BANKS; b++) begin
        ras_cnt[b] <= '0;
        rtp_cnt[b] <= '0;
        ap_cnt[b]  <= '0;
        rp_cnt[b]  <= '0;
      end
    end else begin
      bank_open_o   <= next_open;
      ap_pending_o  <= next_pend;
      ap_start_o    <= next_start;
      precharging_o <= next_prech;
      for (int b = 0; b < `BANKS; b++) begin
        ras_cnt[b] <= next_ras[b];
        rtp_cnt[b] <= next_rtp[b];
        ap_cnt[b]  <= next_ap[b];
        rp_cnt[b]  <= next_rp[b];
      end
    end
  end

  // Read path: token travels RL stages, then BL/2 beats
  always_comb begin
    next_pipe_v = pipe_v >> 1;
    for (int i = 0; i < RL - 1; i++) begin
      next_pipe_col[i] = pipe_col[i + 1];
    end
    next_pipe_col[RL-1] = pipe_col[RL-1];
    if (link.cmd == cmd_read) begin // R15
      next_pipe_v[RL-1]   = 1'b1;
      next_pipe_col[RL-1] = link.col;
    end
    next_beat_left = beat_left;
    next_beat_col  = beat_col;
    next_drive     = 1'b0;
    next_dqs_phase = 1'b0;
    if (pipe_v[0]) begin
      next_beat_left = BEATS;
      next_beat_col  = pipe_col[0];
      next_drive     = 1'b1;
      next_dqs_phase = 1'b1;
    end else if (beat_left != cnt_t'(0)) begin
      next_beat_left = beat_left - cnt_t'(1);
      next_beat_col  = beat_col + `COL_W'(1);
      next_drive     = 1'b1;
      next_dqs_phase = ~dqs_phase;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pipe_v    <= '0;
      beat_left <= '0;
      beat_col  <= '0;
      drive     <= 1'b0;
      dqs_phase <= 1'b0;
      for (int i = 0; i < RL; i++) begin
        pipe_col[i] <= '0;
      end
    end else begin
      pipe_v    <= next_pipe_v;
      beat_left <= next_beat_left;
      beat_col  <= next_beat_col;
      drive     <= next_drive;
      dqs_phase <= next_dqs_phase;
      for (int i = 0; i < RL; i++) begin
        pipe_col[i] <= next_pipe_col[i];
      end
    end
  end

  wire logic [`LANES*`LANE_W-1:0] next_dq;

  // Lane 0 carries the column, lane 1 its complement
  generate
    for (genvar l = 0; l < `LANES; l++) begin : g_lane
      assign next_dq[l*`LANE_W +: `LANE_W] = (l == 0) ? next_beat_col : ~next_beat_col;
    end
  endgenerate

  // Byte lanes, each with its own strobe and enable; one writer for the link
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      link.dq     <= '0;
      link.dq_oe  <= '0;
      link.dqs    <= '0;
      link.dqs_oe <= '0;
    end else begin
      link.dq     <= next_drive ? next_dq : '0; // R14
      link.dq_oe  <= {`LANES{next_drive}}; // R14
      link.dqs    <= {`LANES{next_dqs_phase}}; // R14
      link.dqs_oe <= {`LANES{next_drive}};
    end
  end

endmodule

`default_nettype wire

/* design/ddr2_rap_host.sv */
// DDR2 controller end: command spacing for reads with and without auto precharge
`include "ddr2_rap_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module ddr2_rap_host
  import ddr2_rap_pkg::*;
#(
  parameter int AL = 0,
  parameter int CL = 3,
  parameter int BL = `BL_SHORT
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_i,
  ddr2_link.host                      link,
  input  wire logic                   req_valid_i,
  input  wire op_t                    req_op_i,
  input  wire logic [`BANK_W-1:0]     req_bank_i,
  input  wire logic [`COL_W-1:0]      req_col_i,
  input  wire logic                   req_ap_i,
  output logic                        req_ready_o,
  output logic [`LANES*`LANE_W-1:0]   rdata_o,
  output logic                        rvalid_o
);

  localparam int   HALF     = BL / 2;
  localparam cnt_t RAS_CK   = cnt_t'(`CEIL_CK(`T_RAS_PS));
  localparam cnt_t RTP_CK   = cnt_t'(`CEIL_CK(`T_RTP_PS));
  localparam cnt_t RP_CK    = cnt_t'(`CEIL_CK(`T_RP_PS));
  localparam cnt_t RCD_CK   = cnt_t'(`CEIL_CK(`T_RCD_PS));
  localparam cnt_t RTPRP_CK = cnt_t'(`CEIL_CK(`T_RTP_PS + `T_RP_PS));
  localparam cnt_t BASE     = cnt_t'(AL + HALF - `MIN_PF_GAP);
  localparam cnt_t RDA_ACT  = BASE + RTPRP_CK;
  localparam cnt_t DEV_ACT  = cnt_t'(AL + HALF) + RP_CK;
  localparam cnt_t RD_PRE   = BASE + cmax(cnt_t'(`MIN_PF_GAP), RTP_CK);
  localparam cnt_t RD_GAP   = cnt_t'(HALF);
  localparam cnt_t WR_GAP   = cnt_t'(HALF + `WR_EXTRA);

  generate
    if ((BL != `BL_SHORT && BL != `BL_LONG) || CL < 2 || AL < 0
        || AL + CL > `RL_MAX) begin : g_bad_cfg
      $error("ddr2_rap_host: unsupported AL, CL or BL");
    end
  endgenerate

  state_t             state;
  state_t             next_state;
  op_t                op;
  op_t                next_op;
  logic [`BANK_W-1:0] bank;
  logic [`BANK_W-1:0] next_bank;
  logic [`COL_W-1:0]  col;
  logic [`COL_W-1:0]  next_col;
  logic               ap;
  logic               next_ap;
  logic               next_ready;
  cmd_t               next_cmd;
  logic               next_a10;
  logic [`BANKS-1:0]  open;
  logic [`BANKS-1:0]  next_open;
  cnt_t               act_w [`BANKS];
  cnt_t               pre_w [`BANKS];
  cnt_t               rcd_w [`BANKS];
  cnt_t               next_act_w [`BANKS];
  cnt_t               next_pre_w [`BANKS];
  cnt_t               next_rcd_w [`BANKS];
  cnt_t               rd_w;
  cnt_t               wr_w;
  cnt_t               next_rd_w;
  cnt_t               next_wr_w;

  // Sequencer and spacing counters
  always_comb begin
    next_state = state;
    next_op    = op;
    next_bank  = bank;
    next_col   = col;
    next_ap    = ap;
    next_ready = req_ready_o;
    next_cmd   = cmd_nop;
    next_a10   = 1'b0;
    next_open  = open;
    next_rd_w  = tick(rd_w);
    next_wr_w  = tick(wr_w);
    for (int b = 0; b < `BANKS; b++) begin // R17
      next_act_w[b] = tick(act_w[b]);
      next_pre_w[b] = tick(pre_w[b]);
      next_rcd_w[b] = tick(rcd_w[b]);
    end
    case (state)
      st_idle: begin
        if (req_valid_i && req_ready_o) begin
          next_op    = req_op_i;
          next_bank  = req_bank_i;
          next_col   = req_col_i;
          next_ap    = req_ap_i && (req_op_i == op_read);
          next_ready = 1'b0;
          if (req_op_i == op_pre) begin
            next_state = st_close;
          end else if (open[req_bank_i]) begin
            next_state = st_access;
          end else begin
            next_state = st_open;
          end
        end
      end
      st_open: begin
        if (elapsed(act_w[bank])) begin // R5 R6 R10
          next_cmd          = cmd_act;
          next_open[bank]   = 1'b1;
          next_rcd_w[bank]  = RCD_CK;
          next_pre_w[bank]  = cmax(next_pre_w[bank], RAS_CK); // R13
          next_state        = st_access;
        end
      end
      st_access: begin
        if (elapsed(rcd_w[bank]) && ((op == op_read) ? elapsed(rd_w)
            : elapsed(wr_w))) begin // R10 R11
          next_cmd  = (op == op_read) ? cmd_read : cmd_write;
          next_a10  = ap; // R1
          next_rd_w = RD_GAP; // R10
          next_wr_w = (op == op_read) ? WR_GAP : RD_GAP; // R11
          if (ap) begin // R9
            next_open[bank]  = 1'b0;
            next_act_w[bank] = cmax(cmax(RDA_ACT, DEV_ACT),
                                    next_pre_w[bank] + RP_CK); // R5 R6 R7
          end else if (op == op_read) begin
            next_pre_w[bank] = cmax(next_pre_w[bank], RD_PRE); // R12 R16
          end
          next_state = st_idle;
          next_ready = 1'b1;
        end
      end
      st_close: begin
        if (!open[bank]) begin
          next_state = st_idle;
          next_ready = 1'b1;
        end else if (elapsed(pre_w[bank])) begin // R12 R13
          next_cmd         = cmd_pre;
          next_open[bank]  = 1'b0;
          next_act_w[bank] = RP_CK;
          next_state       = st_idle;
          next_ready       = 1'b1;
        end
      end
      default: begin
        next_state = st_idle;
        next_ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state       <= st_idle;
      op          <= op_read;
      bank        <= '0;
      col         <= '0;
      ap          <= 1'b0;
      req_ready_o <= 1'b1;
      open        <= '0;
      rd_w        <= '0;
      wr_w        <= '0;
      link.cmd    <= cmd_nop;
      link.bank   <= '0;
      link.col    <= '0;
      link.a10    <= 1'b0;
      rdata_o     <= '0;
      rvalid_o    <= 1'b0;
      for (int b = 0; b < `BANKS; b++) begin
        act_w[b] <= '0;
        pre_w[b] <= '0;
        rcd_w[b] <= '0;
      end
    end else begin
      state       <= next_state;
      op          <= next_op;
      bank        <= next_bank;
      col         <= next_col;
      ap          <= next_ap;
      req_ready_o <= next_ready;
      open        <= next_open;
      rd_w        <= next_rd_w;
      wr_w        <= next_wr_w;
      link.cmd    <= next_cmd;
      link.bank   <= next_bank;
      link.col    <= next_col;
      link.a10    <= next_a10;
      rdata_o     <= link.dq; // Captured every cycle; valid only with both lanes driven
      rvalid_o    <= &link.dq_oe;
      for (int b = 0; b < `BANKS; b++) begin
        act_w[b] <= next_act_w[b];
        pre_w[b] <= next_pre_w[b];
        rcd_w[b] <= next_rcd_w[b];
      end
    end
  end

endmodule

`default_nettype wire

/* sim/ddr2_rap_monitor.sv */
// Checker of command spacing and read data on the DDR2 link
`include "ddr2_rap_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module ddr2_rap_monitor
  import ddr2_rap_pkg::*;
#(
  parameter int AL = 0,
  parameter int CL = 3,
  parameter int BL = `BL_SHORT
) (
  input  wire logic                      clock_i,
  input  wire logic                      rst_i,
  input  wire cmd_t                      cmd,
  input  wire logic [`BANK_W-1:0]        bank,
  input  wire logic [`COL_W-1:0]         col,
  input  wire logic                      a10,
  input  wire logic [`LANES*`LANE_W-1:0] dq,
  input  wire logic [`LANES-1:0]         dq_oe,
  input  wire logic [`LANES-1:0]         dqs,
  input  wire logic [`LANES-1:0]         dqs_oe
);
  localparam int RLP     = AL + CL + 1;
  localparam int RTP_CK  = `CEIL_CK(`T_RTP_PS);
  localparam int ACT_GAP = AL + BL / 2 - 2 + `CEIL_CK(`T_RTP_PS + `T_RP_PS);
  localparam int PRE_GAP = AL + BL / 2 - 2 + (RTP_CK > 2 ? RTP_CK : 2);
  localparam int WR_GAP  = BL / 2 + `WR_EXTRA;

  logic [5:0]         since_rd;
  logic [5:0]         since_rda;
  logic [`BANK_W-1:0] rd_bank;
  logic [`BANK_W-1:0] rda_bank;

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  // Cycles since the last read and the last auto-precharge read
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      since_rd  <= 6'h3f;
      since_rda <= 6'h3f;
      rd_bank   <= '0;
      rda_bank  <= '0;
    end else begin
      if (cmd == cmd_read) begin
        since_rd <= 6'h01;
        rd_bank  <= bank;
      end else if (since_rd != 6'h3f) begin
        since_rd <= since_rd + 6'h01;
      end
      if (cmd == cmd_read && a10) begin
        since_rda <= 6'h01;
        rda_bank  <= bank;
      end else if (since_rda != 6'h3f) begin
        since_rda <= since_rda + 6'h01;
      end
    end
  end

  AST_RD_LATENCY: assert property (cmd == cmd_read |-> ##RLP dq_oe == 2'b11)
    else $error("read data enable late or early");
  AST_RD_COLUMN: assert property (cmd == cmd_read |-> ##RLP dq[7:0] == $past(col, RLP))
    else $error("first beat does not carry the column");
  AST_LANE_SPLIT: assert property (dq_oe[0] |-> dq_oe[1] && dq[15:8] == ~dq[7:0])
    else $error("upper lane out of step with lower lane");
  AST_STROBE_EN: assert property (dqs_oe == dq_oe && dqs[1] == dqs[0])
    else $error("strobe enable differs from data enable");
  AST_STROBE_FIRST: assert property ($rose(dq_oe[0]) |-> dqs == 2'b11)
    else $error("strobe not high on first beat");
  AST_STROBE_TOGGLE: assert property (
    dq_oe[0] && $past(dq_oe[0]) |-> dqs[0] != $past(dqs[0]))
    else $error("strobe did not toggle between beats");
  AST_RD_SPACING: assert property (cmd == cmd_read |-> since_rd >= 6'(BL / 2))
    else $error("reads closer than half a burst");
  AST_ACT_AFTER_RDA: assert property (
    cmd == cmd_act && bank == rda_bank |-> since_rda >= 6'(ACT_GAP))
    else $error("activate too soon after auto-precharge read");
  AST_WR_AFTER_RDA: assert property (cmd == cmd_write |-> since_rda >= 6'(WR_GAP))
    else $error("write too soon after auto-precharge read");
  AST_PRE_AFTER_RD: assert property (
    cmd == cmd_pre && bank == rd_bank |-> since_rd >= 6'(PRE_GAP))
    else $error("precharge too soon after read");
endmodule

`default_nettype wire

/* sim/tb.sv */
// Bench for the DDR2 read auto-precharge controller and device pair
`include "ddr2_rap_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module tb;
  import ddr2_rap_pkg::*;
  localparam int AL      = 0;
  localparam int CL      = 3;
  localparam int BL      = `BL_SHORT;
  localparam int RP_CK   = `CEIL_CK(`T_RP_PS);
  localparam int G1      = AL + BL / 2 - 2 + `CEIL_CK(`T_RTP_PS + `T_RP_PS);
  localparam int G2      = AL + BL / 2 + RP_CK;
  localparam int G3      = `CEIL_CK(`T_RAS_PS) + RP_CK;
  localparam int ACT_EXP = G1 > G2 ? (G1 > G3 ? G1 : G3) : (G2 > G3 ? G2 : G3);

  logic               clock_i   = 1'b0;
  logic               rst_i     = 1'b1;
  logic               req_valid = 1'b0;
  op_t                req_op    = op_read;
  logic [`BANK_W-1:0] req_bank  = '0;
  logic [`COL_W-1:0]  req_col   = '0;
  logic               req_ap    = 1'b0;
  logic               ready;
  logic [15:0]        rdata;
  logic               rvalid;
  logic [3:0]         bank_open, ap_pending, ap_start, precharging;
  int                 mismatches = 0;
  int                 compares = 0;
  int                 cyc = 0;
  int                 rd_at, rda_at, act_at, wr_at, rv_at, pc_n, pre_n, pp_n;
  int                 ap_at[4];
  logic [15:0]        rq[$];

  ddr2_link link ();
  ddr2_rap_host #(.AL(AL), .CL(CL), .BL(BL)) ddr2_rap_host_inst (
    .clock_i(clock_i), .rst_i(rst_i), .link(link), .req_valid_i(req_valid),
    .req_op_i(req_op), .req_bank_i(req_bank), .req_col_i(req_col), .req_ap_i(req_ap),
    .req_ready_o(ready), .rdata_o(rdata), .rvalid_o(rvalid));
  ddr2_rap_device #(.AL(AL), .CL(CL), .BL(BL)) ddr2_rap_device_inst (
    .clock_i(clock_i), .rst_i(rst_i), .link(link), .bank_open_o(bank_open),
    .ap_pending_o(ap_pending), .ap_start_o(ap_start), .precharging_o(precharging));
  ddr2_rap_monitor #(.AL(AL), .CL(CL), .BL(BL)) monitor_inst (
    .clock_i(clock_i), .rst_i(rst_i), .cmd(link.cmd), .bank(link.bank), .col(link.col),
    .a10(link.a10), .dq(link.dq), .dq_oe(link.dq_oe), .dqs(link.dqs), .dqs_oe(link.dqs_oe));

  always #20 clock_i = ~clock_i;

  // Records link events and cuts a hang short
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (link.cmd === cmd_read) rd_at = cyc;
    if (link.cmd === cmd_read && link.a10 === 1'b1) rda_at = cyc;
    if (link.cmd === cmd_act) act_at = cyc;
    if (link.cmd === cmd_write) wr_at = cyc;
    if (link.cmd === cmd_pre) pre_n = pre_n + 1;
    if (precharging[0] === 1'b1) pc_n = pc_n + 1;
    if (ap_pending[0] === 1'b1) pp_n = pp_n + 1;
    for (int b = 0; b < 4; b++) if (ap_start[b] === 1'b1) ap_at[b] = cyc;
    if (rvalid === 1'b1) begin
      rq.push_back(rdata);
      if (rv_at < 0) rv_at = cyc;
    end
    if (cyc == 2000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_v(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_n(string what, int exp, int got);
    compares++;
    if (got != exp) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // Expected word of a beat: column low, complement high
  function automatic logic [15:0] word(int c);
    return {~8'(c), 8'(c)};
  endfunction

  task automatic clear();
    rq.delete();
    rv_at = -1;
    pc_n = 0;
    pp_n = 0;
    pre_n = 0;
  endtask

  // Holds a request until the controller takes it
  task automatic issue(op_t op, int b, int c, logic ap);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_op <= op;
    req_bank <= 2'(b);
    req_col <= 8'(c);
    req_ap <= ap;
    do begin
      @(negedge clock_i);
      n++;
    end while (ready !== 1'b1 && n < 40);
    @(posedge clock_i);
  endtask

  task automatic idle(int n);
    req_valid <= 1'b0;
    repeat (n) @(posedge clock_i);
  endtask

  task automatic t_rda_single();
    clear();
    issue(op_read, 0, 8'h10, 1'b1);
    idle(12);
    chk_n("ap start delay", AL + BL / 2 + 1, ap_at[0] - rda_at);
    chk_n("first beat delay", AL + CL + 2, rv_at - rd_at);
    chk_n("beats", BL / 2, rq.size());
    chk_v("beat 0", word(8'h10), rq[0]);
    chk_v("beat 1", word(8'h11), rq[1]);
    chk_n("precharge cycles", RP_CK, pc_n);
    chk_n("pending cycles", AL + BL / 2, pp_n);
    chk_v("open banks", 16'h0000, 16'(bank_open));
    $display("test rda_single done");
  endtask

  task automatic t_concurrent();
    clear();
    issue(op_read, 1, 8'h20, 1'b0);
    issue(op_read, 0, 8'h30, 1'b1);
    issue(op_read, 1, 8'h40, 1'b0);
    idle(14);
    chk_n("ap start delay", AL + BL / 2 + 1, ap_at[0] - rda_at);
    chk_n("beats", 3 * BL / 2, rq.size());
    chk_v("bank 1 read", word(8'h40), rq[BL]);
    chk_v("open banks", 16'h0002, 16'(bank_open));
    $display("test concurrent done");
  endtask

  task automatic t_act_after_rda();
    clear();
    issue(op_read, 2, 8'h50, 1'b1);
    issue(op_read, 2, 8'h60, 1'b0);
    idle(14);
    chk_n("activate gap", ACT_EXP, act_at - rda_at);
    chk_v("reopened read", word(8'h60), rq[BL / 2]);
    chk_v("open banks", 16'h0006, 16'(bank_open));
    $display("test act_after_rda done");
  endtask

  task automatic t_write_pre();
    clear();
    issue(op_read, 2, 8'h70, 1'b0);
    issue(op_write, 1, 8'h00, 1'b1);
    issue(op_pre, 2, 8'h00, 1'b0);
    issue(op_pre, 3, 8'h00, 1'b0);
    idle(12);
    chk_n("write gap", BL / 2 + `WR_EXTRA, wr_at - rd_at);
    chk_n("precharges sent", 1, pre_n);
    chk_v("open banks", 16'h0002, 16'(bank_open));
    $display("test write_pre done");
  endtask

  initial begin
    foreach (ap_at[b]) ap_at[b] = -1;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    t_rda_single();
    t_concurrent();
    t_act_after_rda();
    t_write_pre();
    conclude();
  end
endmodule

`default_nettype wire
